// ---- design/lps_top.v ----
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lps_regs.vh"

// Contract
// - The low prescaler runs from the slow clock when slow enable is 1 and system enable 0, else from a high tap.
// - Writing 1 to the prescaler reset bit clears the low prescaler synchronously.
// - Setting slow enable to 1 clears the low prescaler counter.
// - Setting slow enable to 1 starts a warm-up during which the flag reads 1 and the slow clock is held off.
// - Warm-up ends after 32768 slow clock cycles, the flag drops and the slow clock becomes usable.
// - Without a running slow clock a decoder picks the high tap closest to 32 kHz.
// - The decoder input is divide factor, coarse high, coarse low and fine trim concatenated in that order.
// - The decoder disregards the low fine trim bits beyond its step thresholds.
// - The decoder follows the printed code-to-tap mapping.
// - The decoding applies whether the chain runs from the oscillator or the system clock input.
// - The high prescaler is an eight-stage halving chain fed by the oscillator or system clock input.
// - Trim fields are 3-bit divide, 2-bit coarse high, 2-bit coarse low and fine, coarse high resetting to 01.
module lps_top #(
    parameter STAGES = 8,
    parameter LOW_W = 15,
    parameter WARM_W = 16,
    parameter [WARM_W-1:0] WARMUP_CYCLES = `LPS_WARMUP_SLOW_CYCLES
) (
    input wire CLK_SYS,
    input wire NRST,
    input wire CE,
    input wire INTERNAL_OSC_CLOCK,
    input wire SYSTEM_CLOCK_INPUT,
    input wire SLOW_CLOCK_INPUT,
    output reg [LOW_W-1:0] LOW_PRESC_COUNT,
    output reg LOW_PRESC_TICK,
    output wire IRQ,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    // ------------------------------------------------------------------
    // Tap decoder
    // ------------------------------------------------------------------
    localparam [3:0] EXP_CENTER = `LPS_EXP_CENTER;
    // Step within a block of coarse/fine codes: 0..3 extra halvings
    function [1:0] lps_step;
        input [7:0] b;
        reg [3:0] hi, lo, t;
        begin
            hi = b[7:4];
            lo = b[3:0];
            case (hi)
                4'h0: t = 4'hA;
                4'h1: t = 4'h9;
                4'h2: t = 4'h7;
                4'h3: t = 4'h5;
                4'h4: t = 4'h4;
                4'h5: t = 4'h2;
                4'h6: t = 4'h1;
                4'h8: t = 4'hE;
                4'h9: t = 4'hD;
                4'hA: t = 4'hB;
                4'hB: t = 4'h9;
                4'hC: t = 4'h8;
                4'hD: t = 4'h6;
                4'hE: t = 4'h5;
                4'hF: t = 4'h3;
                default: t = 4'h0;
            endcase
            if (hi == 4'h7) begin
                lps_step = 2'h2;
            end else if (hi[3]) begin
                lps_step = (lo >= t) ? 2'h3 : 2'h2;
            end else if (hi == 4'h0) begin
                lps_step = (lo >= t) ? 2'h2 : ((lo >= 4'h2) ? 2'h1 : 2'h0);
            end else begin
                lps_step = (lo >= t) ? 2'h2 : 2'h1;
            end
        end
    endfunction

    // Tap exponent: 6 minus divide factor plus step, held to 0..7
    function [3:0] lps_tap_exp;
        input [10:0] code;
        reg [4:0] e;
        begin
            e = {2'h0, EXP_CENTER[2:0]} + {3'h0, lps_step(code[7:0])};
            if (e < {2'h0, code[10:8]}) begin
                lps_tap_exp = 4'h0;
            end else begin
                e = e - {2'h0, code[10:8]};
                lps_tap_exp = (e > {1'b0, `LPS_EXP_MAX}) ? `LPS_EXP_MAX : e[3:0];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    reg slow_clock_enable;
    reg system_clock_enable;
    reg [2:0] trim_divide_factor;
    reg [1:0] coarse_trim_high;
    reg [1:0] coarse_trim_low;
    reg [3:0] fine_trim;
    reg slow_clock_warmup_flag;
    reg [WARM_W-1:0] warm_count;
    reg slow_prev;
    reg sel_slow;
    reg [2:0] sel_exp;
    reg low_prev;
    reg [`LPS_IRQ_W-1:0] irq_status;
    reg [`LPS_IRQ_W-1:0] irq_mask;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire [STAGES-1:0] tap_level;
    wire [10:0] trim_code;
    wire [3:0] want_exp;
    wire want_slow, slow_rise, cur_level, new_level, low_rise;
    wire wr_fire, rd_fire, ctrl_wr, pres_rst_cmd, slow_en_rise, warm_done, low_wrap;
    wire [`LPS_IRQ_W-1:0] irq_events;
    wire irq_clear;

    // ------------------------------------------------------------------
    // High prescaler and tap selection
    // ------------------------------------------------------------------
    lps_high_chain #(
        .STAGES(STAGES)
    ) u_chain (
        .clk(CLK_SYS),
        .rst_n(NRST),
        .ce(CE),
        .src_level(system_clock_enable ? SYSTEM_CLOCK_INPUT : INTERNAL_OSC_CLOCK),
        .tap_level(tap_level)
    );

    assign trim_code = {trim_divide_factor, coarse_trim_high, coarse_trim_low, fine_trim};
    assign want_exp = lps_tap_exp(trim_code);
    assign want_slow = slow_clock_enable & ~system_clock_enable & ~slow_clock_warmup_flag;
    assign slow_rise = SLOW_CLOCK_INPUT & ~slow_prev;
    assign cur_level = sel_slow ? SLOW_CLOCK_INPUT : tap_level[sel_exp];
    assign new_level = want_slow ? SLOW_CLOCK_INPUT : tap_level[want_exp[2:0]];
    assign low_rise = cur_level & ~low_prev;

    // Selection moves only while both old and new inputs are low
    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            sel_slow <= 1'b0;
            sel_exp <= EXP_CENTER[2:0];
            low_prev <= 1'b0;
            slow_prev <= 1'b0;
        end else if (CE) begin
            slow_prev <= SLOW_CLOCK_INPUT;
            if (!cur_level && !new_level) begin
                sel_slow <= want_slow;
                sel_exp <= want_exp[2:0];
                low_prev <= 1'b0;
            end else begin
                low_prev <= cur_level;
            end
        end
    end

    // ------------------------------------------------------------------
    // Low prescaler and warm-up
    // ------------------------------------------------------------------
    assign ctrl_wr = wr_fire && (aw_addr == `LPS_ADDR_CTRL) && w_strb[0];
    assign pres_rst_cmd = ctrl_wr && w_data[`LPS_CTRL_PRES_RST];
    assign slow_en_rise = ctrl_wr && w_data[`LPS_CTRL_SLOW_EN] && !slow_clock_enable;
    assign warm_done = slow_clock_warmup_flag && slow_rise && slow_clock_enable
        && (warm_count == WARMUP_CYCLES - 1'b1);
    assign low_wrap = low_rise && (&LOW_PRESC_COUNT);

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            LOW_PRESC_COUNT <= {LOW_W{1'b0}};
            LOW_PRESC_TICK <= 1'b0;
            slow_clock_warmup_flag <= 1'b0;
            warm_count <= {WARM_W{1'b0}};
        end else if (CE) begin
            LOW_PRESC_TICK <= low_rise;
            if (pres_rst_cmd) begin
                LOW_PRESC_COUNT <= {LOW_W{1'b0}};
            end else if (slow_en_rise) begin
                LOW_PRESC_COUNT <= {LOW_W{1'b0}};
            end else if (low_rise) begin
                LOW_PRESC_COUNT <= LOW_PRESC_COUNT + 1'b1;
            end
            if (slow_en_rise) begin
                slow_clock_warmup_flag <= 1'b1;
                warm_count <= {WARM_W{1'b0}};
            end else if (!slow_clock_enable) begin
                slow_clock_warmup_flag <= 1'b0;
            end else if (warm_done) begin
                slow_clock_warmup_flag <= 1'b0;
            end else if (slow_clock_warmup_flag && slow_rise) begin
                warm_count <= warm_count + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_events = {low_wrap, warm_done};
    assign irq_clear = rd_fire && (S_AXI_ARADDR == `LPS_ADDR_IRQ_ST);
    assign IRQ = |(irq_status & irq_mask);

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            irq_status <= {`LPS_IRQ_W{1'b0}};
        end else if (CE) begin
            // A new event wins over the clearing read
            irq_status <= (irq_clear ? {`LPS_IRQ_W{1'b0}} : irq_status) | irq_events;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `LPS_RESP_OKAY;
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                case (aw_addr)
                    `LPS_ADDR_CTRL, `LPS_ADDR_TRIM1, `LPS_ADDR_TRIM2, `LPS_ADDR_IRQ_MASK,
                    `LPS_ADDR_STATUS, `LPS_ADDR_IRQ_ST, `LPS_ADDR_COUNT: begin
                        S_AXI_BRESP <= `LPS_RESP_OKAY;
                    end
                    default: begin
                        S_AXI_BRESP <= `LPS_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            slow_clock_enable <= 1'b0;
            system_clock_enable <= 1'b0;
            trim_divide_factor <= `LPS_RST_DIV;
            coarse_trim_high <= `LPS_RST_CHI;
            coarse_trim_low <= `LPS_RST_CLO;
            fine_trim <= `LPS_RST_FINE;
            irq_mask <= {`LPS_IRQ_W{1'b0}};
        end else if (CE && wr_fire && w_strb[0]) begin
            case (aw_addr)
                `LPS_ADDR_CTRL: begin
                    slow_clock_enable <= w_data[`LPS_CTRL_SLOW_EN];
                    system_clock_enable <= w_data[`LPS_CTRL_SYS_EN];
                end
                `LPS_ADDR_TRIM1: begin
                    trim_divide_factor <= w_data[`LPS_TRIM1_DIV_HI:`LPS_TRIM1_DIV_LO];
                    coarse_trim_high <= w_data[`LPS_TRIM1_CHI_HI:`LPS_TRIM1_CHI_LO];
                end
                `LPS_ADDR_TRIM2: begin
                    coarse_trim_low <= w_data[`LPS_TRIM2_CLO_HI:`LPS_TRIM2_CLO_LO];
                    fine_trim <= w_data[`LPS_TRIM2_FINE_HI:`LPS_TRIM2_FINE_LO];
                end
                `LPS_ADDR_IRQ_MASK: begin
                    irq_mask <= w_data[`LPS_IRQ_W-1:0];
                end
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `LPS_RESP_OKAY;
        end else if (CE) begin
            if (rd_fire) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `LPS_RESP_OKAY;
                S_AXI_RDATA <= 32'h00000000;
                case (S_AXI_ARADDR)
                    `LPS_ADDR_CTRL: begin
                        S_AXI_RDATA[`LPS_CTRL_SLOW_EN] <= slow_clock_enable;
                        S_AXI_RDATA[`LPS_CTRL_SYS_EN] <= system_clock_enable;
                    end
                    `LPS_ADDR_TRIM1: begin
                        S_AXI_RDATA[`LPS_TRIM1_DIV_HI:`LPS_TRIM1_DIV_LO] <= trim_divide_factor;
                        S_AXI_RDATA[`LPS_TRIM1_CHI_HI:`LPS_TRIM1_CHI_LO] <= coarse_trim_high;
                    end
                    `LPS_ADDR_TRIM2: begin
                        S_AXI_RDATA[`LPS_TRIM2_CLO_HI:`LPS_TRIM2_CLO_LO] <= coarse_trim_low;
                        S_AXI_RDATA[`LPS_TRIM2_FINE_HI:`LPS_TRIM2_FINE_LO] <= fine_trim;
                    end
                    `LPS_ADDR_STATUS: begin
                        S_AXI_RDATA[`LPS_ST_WARMUP] <= slow_clock_warmup_flag;
                        S_AXI_RDATA[`LPS_ST_SLOW_SEL] <= sel_slow;
                        S_AXI_RDATA[`LPS_ST_EXP_LO+2:`LPS_ST_EXP_LO] <= sel_exp;
                    end
                    `LPS_ADDR_IRQ_ST: begin
                        S_AXI_RDATA[`LPS_IRQ_W-1:0] <= irq_status;
                    end
                    `LPS_ADDR_IRQ_MASK: begin
                        S_AXI_RDATA[`LPS_IRQ_W-1:0] <= irq_mask;
                    end
                    `LPS_ADDR_COUNT: begin
                        S_AXI_RDATA[LOW_W-1:0] <= LOW_PRESC_COUNT;
                    end
                    default: begin
                        S_AXI_RRESP <= `LPS_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule // lps_top

// ---- design/lps_regs.vh ----
`ifndef LPS_REGS_VH
`define LPS_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define LPS_ADDR_CTRL 8'h00
`define LPS_ADDR_TRIM1 8'h04
`define LPS_ADDR_TRIM2 8'h08
`define LPS_ADDR_STATUS 8'h0C
`define LPS_ADDR_IRQ_ST 8'h10
`define LPS_ADDR_IRQ_MASK 8'h14
`define LPS_ADDR_COUNT 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LPS_CTRL_PRES_RST 0
`define LPS_CTRL_SLOW_EN 1
`define LPS_CTRL_SYS_EN 2
`define LPS_TRIM1_DIV_HI 4
`define LPS_TRIM1_DIV_LO 2
`define LPS_TRIM1_CHI_HI 1
`define LPS_TRIM1_CHI_LO 0
`define LPS_TRIM2_CLO_HI 5
`define LPS_TRIM2_CLO_LO 4
`define LPS_TRIM2_FINE_HI 3
`define LPS_TRIM2_FINE_LO 0
`define LPS_ST_WARMUP 0
`define LPS_ST_SLOW_SEL 1
`define LPS_ST_EXP_LO 4
`define LPS_IRQ_WARM_DONE 0
`define LPS_IRQ_WRAP 1
`define LPS_IRQ_W 2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define LPS_RST_DIV 3'h0
`define LPS_RST_CHI 2'h1
`define LPS_RST_CLO 2'h0
`define LPS_RST_FINE 4'h0
`define LPS_WARMUP_SLOW_CYCLES 32768
`define LPS_EXP_CENTER 4'h6
`define LPS_EXP_MAX 4'h7
`define LPS_RESP_OKAY 2'h0
`define LPS_RESP_SLVERR 2'h2

`endif

// ---- design/lps_high_chain.v ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Divide-by-two chain on sampled source edges
// ----------------------------------------------------------------------
module lps_high_chain #(
    parameter STAGES = 8
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire src_level,
    output wire [STAGES-1:0] tap_level
);
    reg src_prev;
    reg [STAGES-1:0] count;
    wire src_rise;

    assign src_rise = src_level & ~src_prev;

    always @(posedge clk) begin
        if (!rst_n) begin
            src_prev <= 1'b0;
            count <= {STAGES{1'b0}};
        end else if (ce) begin
            src_prev <= src_level;
            if (src_rise) begin
                count <= count + 1'b1;
            end
        end
    end

    // Tap 0 is the undivided source, tap k is the source divided by 2^k
    assign tap_level[0] = src_level;
    genvar k;
    generate
        for (k = 1; k < STAGES; k = k + 1) begin : g_tap
            assign tap_level[k] = count[k-1];
        end
    endgenerate
endmodule // lps_high_chain

// ---- bench/lps_top_asserts.sv ----
`timescale 1ns/1ps
`include "lps_regs.vh"

// ----------------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------------
module lps_top_asserts #(
    parameter LOW_W = 15
) (
    input wire CLK_SYS,
    input wire NRST,
    input wire CE,
    input wire [LOW_W-1:0] LOW_PRESC_COUNT,
    input wire LOW_PRESC_TICK,
    input wire IRQ,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire S_AXI_BVALID,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    sequence s_wr_taken;
        CE && S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rd_taken;
        CE && S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    property p_reset_idle;
        disable iff (1'b0)
        !NRST |=> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ && LOW_PRESC_COUNT == 0;
    endproperty
    property p_wr_resp;
        s_wr_taken |-> ##[1:2] S_AXI_BVALID;
    endproperty
    property p_rd_resp;
        s_rd_taken |=> S_AXI_RVALID;
    endproperty
    property p_ar_block;
        S_AXI_RVALID |-> !S_AXI_ARREADY;
    endproperty
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=>
            S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP);
    endproperty
    property p_unmapped;
        s_rd_taken ##0 (S_AXI_ARADDR == 8'h1C) |=>
            S_AXI_RRESP == `LPS_RESP_SLVERR && S_AXI_RDATA == 32'h0;
    endproperty
    property p_pres_rst;
        s_wr_taken ##0 (S_AXI_AWADDR == `LPS_ADDR_CTRL && S_AXI_WDATA[0] && S_AXI_WSTRB[0])
            |-> ##[1:3] LOW_PRESC_COUNT == 0;
    endproperty
    property p_tick_pulse;
        LOW_PRESC_TICK |=> !LOW_PRESC_TICK;
    endproperty
    property p_count_step;
        !$stable(LOW_PRESC_COUNT) |->
            LOW_PRESC_COUNT == 0 || LOW_PRESC_COUNT == $past(LOW_PRESC_COUNT) + 1'b1;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("state not idle after reset");
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
    a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_pres_rst: assert property (p_pres_rst) else $error("counter not cleared");
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    a_count_step: assert property (p_count_step) else $error("counter jumped");
endmodule // lps_top_asserts

bind lps_top lps_top_asserts #(.LOW_W(LOW_W)) u_lps_top_asserts (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .LOW_PRESC_COUNT(LOW_PRESC_COUNT),
    .LOW_PRESC_TICK(LOW_PRESC_TICK), .IRQ(IRQ), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ---- bench/lps_slow_src.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// External slow clock, idle low between bursts
// ----------------------------------------------------------------------
module lps_slow_src (
    input wire clk,
    input wire enable,
    input wire [3:0] half_cycles,
    output reg slow_out = 1'b0,
    output reg [15:0] edges = 16'h0000
);
    reg [3:0] ph = 4'h0;
    always @(posedge clk) begin
        if (slow_out) begin
            ph <= (ph >= half_cycles) ? 4'h1 : ph + 4'h1;
            slow_out <= (ph < half_cycles);
        end else if (ph >= half_cycles && enable) begin
            slow_out <= 1'b1;
            ph <= 4'h1;
            edges <= edges + 16'h0001;
        end else if (ph < half_cycles) begin
            ph <= ph + 4'h1;
        end
    end
endmodule // lps_slow_src

// ---- bench/lps_top_bench.sv ----
`timescale 1ns/1ps
`include "lps_regs.vh"

module lps_top_bench;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg osc = 1'b0;
    reg sysin = 1'b0;
    reg sen = 1'b0;
    reg ce = 1'b1;
    reg [3:0] half = 4'h3;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [31:0] rd;
    reg [1:0] rs;
    wire [14:0] cnt;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] sedges;
    wire tick, irq, awready, wready, bvalid, arready, rvalid, slow;
    int fail_count = 0;
    int num_checks = 0;
    reg [10:0] codes [15] = '{11'h000, 11'h001, 11'h002, 11'h100, 11'h102, 11'h10A,
        11'h110, 11'h119, 11'h200, 11'h500, 11'h502, 11'h50A, 11'h519, 11'h600, 11'h700};
    reg [2:0] exps [15] = '{6, 6, 7, 5, 6, 7, 6, 7, 4, 1, 2, 3, 3, 0, 0};

    always #2 clk = ~clk;

    lps_top #(.WARMUP_CYCLES(16'h0004)) u_lps_top (
        .CLK_SYS(clk), .NRST(nrst), .CE(ce), .INTERNAL_OSC_CLOCK(osc),
        .SYSTEM_CLOCK_INPUT(sysin), .SLOW_CLOCK_INPUT(slow), .LOW_PRESC_COUNT(cnt),
        .LOW_PRESC_TICK(tick), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    lps_slow_src u_lps_slow_src (.clk(clk), .enable(sen), .half_cycles(half),
        .slow_out(slow), .edges(sedges));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg done;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Read ready comes late on purpose, so the answer must be held
    task rdr(input [7:0] a);
        reg done;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end else if (rvalid) rready <= 1'b1;
        end
    endtask
    task trim(input [10:0] c);
        wr(`LPS_ADDR_TRIM1, {27'h0, c[10:6]});
        wr(`LPS_ADDR_TRIM2, {26'h0, c[5:0]});
    endtask
    task pulses(input int n, input bit sys);
        repeat (n) begin
            @(posedge clk);
            if (sys) sysin <= 1'b1;
            else osc <= 1'b1;
            repeat (2) @(posedge clk);
            sysin <= 1'b0;
            osc <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
    task slow_run(input [15:0] n);
        reg [15:0] t;
        t = sedges + n;
        sen <= 1'b1;
        while (sedges !== t) @(posedge clk);
        sen <= 1'b0;
        repeat (30) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        rdr(`LPS_ADDR_TRIM1);
        check("trim1 reset", rd, 32'h1);
        rdr(`LPS_ADDR_TRIM2);
        check("trim2 reset", rd, 32'h0);
        rdr(`LPS_ADDR_STATUS);
        check("status reset", rd, 32'h70);
        rdr(8'h1C);
        check("unmapped read", {rs, rd[29:0]}, {`LPS_RESP_SLVERR, 30'h0});
        wr(8'h1C, 32'h1);
        check("unmapped write", rs, `LPS_RESP_SLVERR);
    endtask
    task t_decode;
        for (int i = 0; i < 15; i++) begin
            trim(codes[i]);
            rdr(`LPS_ADDR_STATUS);
            check("tap exponent", rd[6:4], exps[i]);
        end
    endtask
    task t_count(input [10:0] c, input [2:0] e, input bit sys, input [31:0] want);
        reg [14:0] b;
        trim(c);
        b = cnt;
        pulses(3 << e, sys);
        check("low count", cnt - b, want);
    endtask
    task t_counts;
        t_count(11'h500, 3'h1, 1'b0, 32'h3);
        t_count(11'h200, 3'h4, 1'b0, 32'h3);
        wr(`LPS_ADDR_CTRL, 32'h4);
        t_count(11'h500, 3'h1, 1'b1, 32'h3);
        t_count(11'h500, 3'h1, 1'b0, 32'h0);
        wr(`LPS_ADDR_CTRL, 32'h0);
    endtask
    task t_slow;
        reg [14:0] b;
        wr(`LPS_ADDR_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        check("clear on enable", cnt, 15'h0);
        slow_run(3);
        rdr(`LPS_ADDR_STATUS);
        check("warm status", rd[1:0], 2'b01);
        check("held off", cnt, 15'h0);
        half <= 4'h7;
        slow_run(1);
        rdr(`LPS_ADDR_STATUS);
        check("warm done", rd[1:0], 2'b10);
        check("irq masked", irq, 1'b0);
        b = cnt;
        slow_run(5);
        check("slow count", cnt - b, 32'h5);
        wr(`LPS_ADDR_IRQ_MASK, 32'h1);
        check("irq raised", irq, 1'b1);
        rdr(`LPS_ADDR_IRQ_ST);
        check("irq status", rd, 32'h1);
        check("irq cleared", irq, 1'b0);
        rdr(`LPS_ADDR_IRQ_ST);
        check("irq status clear", rd, 32'h0);
        wr(`LPS_ADDR_CTRL, 32'h6);
        b = cnt;
        slow_run(4);
        check("sys blocks slow", cnt - b, 32'h0);
    endtask
    task t_pres;
        check("count nonzero", cnt != 15'h0, 1'b1);
        wr(`LPS_ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        check("prescaler reset", cnt, 15'h0);
        rdr(`LPS_ADDR_CTRL);
        check("reset bit reads", rd[0], 1'b0);
    endtask
    // Source pulses while the enable is low must leave the counter alone
    task t_freeze;
        reg [14:0] b;
        b = cnt;
        ce <= 1'b0;
        pulses(4, 1'b1);
        ce <= 1'b1;
        check("frozen count", cnt, b);
    endtask

    initial begin
        #100000;
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_decode;
        t_counts;
        t_slow;
        t_freeze;
        t_pres;
        end_sim;
    end
endmodule // lps_top_bench
